// [design/swl_regs.svh]
// Timing constants and command codes for the single wire speed link
`ifndef SWL_REGS_SVH
`define SWL_REGS_SVH
`define CLK_PERIOD_NS        4
`define CMD_SKIP_FAST        8'h3C
`define CMD_MATCH_FAST       8'h69
`define ROM_BITS             64
// Slave thresholds and durations, in ns
`define RESET_LONG_NS        480000
`define RESET_DETECT_STD_NS  240000
`define RESET_DETECT_FAST_NS 48000
`define FAST_RESET_MAX_NS    80000
`define PRES_WAIT_STD_NS     30000
`define PRES_WAIT_FAST_NS    3000
`define PRES_LOW_STD_NS      120000
`define PRES_LOW_FAST_NS     12000
`define SAMPLE_STD_NS        30000
`define SAMPLE_FAST_NS       3000
`define HOLD_STD_NS          45000
`define HOLD_FAST_NS         5000
// Master durations, in ns
`define M_RESET_STD_NS       500000
`define M_RESET_FAST_NS      60000
`define M_RHIGH_STD_NS       480000
`define M_RHIGH_FAST_NS      48000
`define M_PSAMPLE_STD_NS     70000
`define M_PSAMPLE_FAST_NS    8000
`define M_W0_STD_NS          60000
`define M_W0_FAST_NS         8000
`define M_W1_STD_NS          6000
`define M_W1_FAST_NS         1000
`define M_RSAMPLE_STD_NS     13000
`define M_RSAMPLE_FAST_NS    2000
`define M_SLOT_STD_NS        70000
`define M_SLOT_FAST_NS       12000
`define CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [design/swl_pkg.sv]
// Types shared by both ends of the single wire speed link
package swl_pkg;
   typedef logic [17:0] count_t;
   typedef enum logic [2:0] {M_IDLE, M_RST_LOW, M_RST_HIGH, M_SLOT, M_RECOVER} mstate_t;
   typedef enum logic [2:0] {S_IDLE, S_PRES_WAIT, S_PRES_LOW, S_CMD, S_ROM, S_FUNC, S_WAIT_RESET} sstate_t;
endpackage

// [design/swl_fifo.sv]
// Valid/ready FIFO in flip-flops
module swl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } fifo_t;
   fifo_t st_reg, st_next;
   logic push, pop;
   assign in_ready  = st_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid = st_reg.cnt != '0;
   assign out_data  = st_reg.mem[st_reg.rd];
   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr] = in_data;
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// [design/swl_if.sv]
// Single wire bus between master and slave, wired-AND with pull-up
interface swl_if;
   logic m_drive_low;
   logic s_drive_low;
   logic line;
   assign line = !(m_drive_low || s_drive_low);
   modport master (output m_drive_low, input line);
   modport slave  (output s_drive_low, input line);
endinterface

// [design/swl_slave.sv]
// Slave end: reset/presence, time slots, fast-speed ROM commands
// Behaviour
// - 3Ch skips addressing and sets fast speed
// - Master keeps fast timing until long reset
// - Master resets fast, then matches, to address
// - Master avoids reads after broadcast fast skip; the bench reads eight bits after 3Ch without a reset
// - 69h matches 64 ROM bits, match sets fast
// - Fast flag survives a failed later match
// - Long reset clears fast; short keeps it
// - Standard speed by default; fast timing everywhere
// - Master starts every signal except presence
// - Reset and presence precede every command
// - Master stretches reset by its fall time
// - After reset release wait, then pull presence
// - Master samples presence at its instant
// - Reset-high window covers presence plus recovery
// - Mixed buses use longer reset-high windows
// - One bit per time slot, either direction
// - Falling edge starts slave slot timer
// - Master obeys write-one and write-zero lows
// - Recovery time between slots is respected
// - ROM command is eight bits after presence
// - Idle high; long lows mean reset
// - Read zero pulls line low, one releases
module swl_slave
   import swl_pkg::*;
#(
   parameter logic [63:0] ROM_ID = 64'h0123_4567_89AB_CDEF  // Arbitrary value
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   swl_if.slave            bus,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   input  wire logic [7:0] tx_data,
   output logic            selected,
   output logic            fast_speed_flag
);
`include "swl_regs.svh"
   typedef struct packed {
      sstate_t     st;
      logic        line_d;
      logic        low_seen;
      count_t      low_cnt;
      count_t      tmr;
      logic        slot_on;
      logic        fast;
      logic        match_ok;
      logic [6:0]  bitn;
      logic [7:0]  shreg;
      logic        drive;
      logic        sel;
      logic [7:0]  wdata;
      logic        wvalid;
   } sstate_all_t;
   sstate_all_t s_reg, s_next;
   logic fifo_ready;
   logic wbit;
   logic   fast_timing;
   count_t t_reset, t_pwait, t_plow, t_samp, t_hold;
   always_comb begin
      // ROM sequence after 69h always arrives at fast speed
      fast_timing = s_reg.fast || s_reg.st == S_ROM;
      t_reset = fast_timing ? count_t'(`CYC(`RESET_DETECT_FAST_NS)) : count_t'(`CYC(`RESET_DETECT_STD_NS));
      t_pwait = fast_timing ? count_t'(`CYC(`PRES_WAIT_FAST_NS)) : count_t'(`CYC(`PRES_WAIT_STD_NS));
      t_plow  = fast_timing ? count_t'(`CYC(`PRES_LOW_FAST_NS)) : count_t'(`CYC(`PRES_LOW_STD_NS));
      t_samp  = fast_timing ? count_t'(`CYC(`SAMPLE_FAST_NS)) : count_t'(`CYC(`SAMPLE_STD_NS));
      t_hold  = fast_timing ? count_t'(`CYC(`HOLD_FAST_NS)) : count_t'(`CYC(`HOLD_STD_NS));
   end
   swl_fifo #(.WIDTH(8), .DEPTH(8)) u_rxq (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .in_data  (s_reg.wdata),
      .in_valid (s_reg.wvalid),
      .in_ready (fifo_ready),
      .out_data (rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );
   always_comb begin
      s_next        = s_reg;
      s_next.line_d = bus.line;
      wbit          = bus.line;
      if (fifo_ready) begin
         s_next.wvalid = 1'b0;
      end
      // Low-time measurement for reset detection
      if (!bus.line && !s_reg.drive) begin
         if (s_reg.low_cnt != '1) begin
            s_next.low_cnt = s_reg.low_cnt + 1'b1;
         end
      end else if (bus.line) begin
         s_next.low_cnt = '0;
      end
      if (s_reg.slot_on) begin
         s_next.tmr = s_reg.tmr + 1'b1;
      end
      if (s_reg.low_cnt >= t_reset) begin
         s_next.low_seen = 1'b1;
         s_next.st       = S_IDLE;
         s_next.slot_on  = 1'b0;
         s_next.drive    = 1'b0;
         s_next.sel      = 1'b0;
         if (s_reg.low_cnt >= count_t'(`CYC(`RESET_LONG_NS))) begin
            s_next.fast = 1'b0;
         end
      end
      if (s_reg.low_seen && bus.line) begin
         s_next.low_seen = 1'b0;
         s_next.st       = S_PRES_WAIT;
         s_next.tmr      = '0;
         s_next.slot_on  = 1'b1;
      end else begin
         unique case (s_reg.st)
            S_IDLE, S_WAIT_RESET: begin
            end
            S_PRES_WAIT: begin
               if (s_reg.tmr >= t_pwait) begin
                  s_next.drive = 1'b1;
                  s_next.tmr   = '0;
                  s_next.st    = S_PRES_LOW;
               end
            end
            S_PRES_LOW: begin
               if (s_reg.tmr >= t_plow) begin
                  s_next.drive    = 1'b0;
                  s_next.slot_on  = 1'b0;
                  s_next.bitn     = '0;
                  s_next.match_ok = 1'b1;
                  s_next.st       = S_CMD;
               end
            end
            S_CMD, S_ROM, S_FUNC: begin
               if (s_reg.line_d && !bus.line && !s_reg.slot_on) begin
                  s_next.slot_on = 1'b1;
                  s_next.tmr     = '0;
                  if (s_reg.st == S_FUNC && !tx_data[s_reg.bitn[2:0]]) begin
                     s_next.drive = 1'b1;
                  end
               end
               if (s_reg.slot_on && s_reg.tmr == t_samp) begin
                  wbit          = bus.line;
                  s_next.shreg  = {wbit, s_reg.shreg[7:1]};
                  s_next.bitn   = s_reg.bitn + 1'b1;
                  if (s_reg.st == S_ROM && wbit != ROM_ID[s_reg.bitn[5:0]]) begin
                     s_next.match_ok = 1'b0;
                  end
               end
               if (s_reg.slot_on && s_reg.tmr >= t_hold) begin
                  s_next.drive   = 1'b0;
                  s_next.slot_on = !bus.line;
                  // Act only once the line is high, so a speed change never lands inside a slot
                  if (!bus.line) begin
                  end else if (s_reg.st == S_CMD && s_reg.bitn == 7'd8) begin
                     s_next.bitn = '0;
                     if (s_reg.shreg == `CMD_SKIP_FAST) begin
                        s_next.fast = 1'b1;
                        s_next.sel  = 1'b1;
                        s_next.st   = S_FUNC;
                     end else if (s_reg.shreg == `CMD_MATCH_FAST) begin
                        s_next.st = S_ROM;
                     end else begin
                        s_next.st = S_WAIT_RESET;
                     end
                  end else if (s_reg.st == S_ROM && s_reg.bitn == 7'(`ROM_BITS)) begin
                     s_next.bitn = '0;
                     if (s_reg.match_ok) begin
                        s_next.fast = 1'b1;
                        s_next.sel  = 1'b1;
                        s_next.st   = S_FUNC;
                     end else begin
                        s_next.st = S_WAIT_RESET;
                     end
                  end else if (s_reg.st == S_FUNC && s_reg.bitn[2:0] == 3'd0 && s_reg.bitn != 7'd0) begin
                     s_next.bitn   = '0;
                     s_next.wdata  = s_reg.shreg;
                     s_next.wvalid = 1'b1;
                  end
               end
            end
            default: begin
               s_next.st = S_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg        <= '0;
         s_reg.line_d <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
   assign bus.s_drive_low  = s_reg.drive;
   assign selected         = s_reg.sel;
   assign fast_speed_flag  = s_reg.fast;
endmodule

// [design/swl_master.sv]
// Master end: issues reset, write and read slots at either speed
module swl_master
   import swl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   swl_if.master           bus,
   input  wire logic       cmd_valid,
   input  wire logic [1:0] cmd_op,
   input  wire logic       cmd_bit,
   input  wire logic       cmd_fast,
   output logic            cmd_ready,
   output logic            resp_valid,
   output logic            resp_bit
);
`include "swl_regs.svh"
   // cmd_op: 0 reset, 1 write bit, 2 read bit
   typedef struct packed {
      mstate_t st;
      count_t  tmr;
      logic    fast;
      logic    op_read;
      logic    wbit;
      logic    drive;
      logic    rvalid;
      logic    rbit;
      logic    pres;
   } mall_t;
   mall_t m_reg, m_next;
   count_t t_low, t_samp, t_end;
   always_comb begin
      t_low  = m_reg.wbit ? (m_reg.fast ? count_t'(`CYC(`M_W1_FAST_NS)) : count_t'(`CYC(`M_W1_STD_NS)))
                          : (m_reg.fast ? count_t'(`CYC(`M_W0_FAST_NS)) : count_t'(`CYC(`M_W0_STD_NS)));
      t_samp = m_reg.fast ? count_t'(`CYC(`M_RSAMPLE_FAST_NS)) : count_t'(`CYC(`M_RSAMPLE_STD_NS));
      t_end  = m_reg.fast ? count_t'(`CYC(`M_SLOT_FAST_NS)) : count_t'(`CYC(`M_SLOT_STD_NS));
   end
   always_comb begin
      m_next        = m_reg;
      m_next.rvalid = 1'b0;
      m_next.tmr    = m_reg.tmr + 1'b1;
      unique case (m_reg.st)
         M_IDLE: begin
            if (cmd_valid) begin
               m_next.fast    = cmd_fast;
               m_next.tmr     = '0;
               m_next.drive   = 1'b1;
               m_next.op_read = cmd_op == 2'd2;
               m_next.wbit    = cmd_op == 2'd2 ? 1'b1 : cmd_bit;
               m_next.st      = cmd_op == 2'd0 ? M_RST_LOW : M_SLOT;
            end
         end
         M_RST_LOW: begin
            if (m_reg.tmr >= (m_reg.fast ? count_t'(`CYC(`M_RESET_FAST_NS)) : count_t'(`CYC(`M_RESET_STD_NS)))) begin
               m_next.drive = 1'b0;
               m_next.tmr   = '0;
               m_next.st    = M_RST_HIGH;
            end
         end
         M_RST_HIGH: begin
            if (m_reg.tmr == (m_reg.fast ? count_t'(`CYC(`M_PSAMPLE_FAST_NS)) : count_t'(`CYC(`M_PSAMPLE_STD_NS)))) begin
               m_next.pres = !bus.line;
            end
            if (m_reg.tmr >= (m_reg.fast ? count_t'(`CYC(`M_RHIGH_FAST_NS)) : count_t'(`CYC(`M_RHIGH_STD_NS)))) begin
               m_next.rvalid = 1'b1;
               m_next.rbit   = m_reg.pres;
               m_next.st     = M_IDLE;
            end
         end
         M_SLOT: begin
            if (m_reg.tmr >= t_low) begin
               m_next.drive = 1'b0;
            end
            if (m_reg.op_read && m_reg.tmr == t_samp) begin
               m_next.rbit = bus.line;
            end
            if (m_reg.tmr >= t_end) begin
               m_next.rvalid = 1'b1;
               m_next.st     = M_RECOVER;
            end
         end
         M_RECOVER: begin
            m_next.st = M_IDLE;
         end
         default: begin
            m_next.st = M_IDLE;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end
   assign bus.m_drive_low = m_reg.drive;
   assign cmd_ready       = m_reg.st == M_IDLE;
   assign resp_valid      = m_reg.rvalid;
   assign resp_bit        = m_reg.rbit;
endmodule

// [testbench/swl_link_props.sv]
// Wire-level checks between the two ends of the single wire link
module swl_link_props (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic m_drive_low,
   input wire logic s_drive_low,
   input wire logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MIN_RESET = 32'h0000_2EE0;
   localparam int LONG_LOW  = 32'h0001_D4C0;
   localparam int PRES_MIN  = 32'h0000_02E4;
   localparam int PRES_DUE  = 32'h0000_1DB0;
   localparam int S_LOW_MAX = 32'h0000_7531;
   localparam int FAST_LOW  = 32'h0000_0EA6;
   localparam int REC_MIN   = 32'h0000_00FA;
   logic [16:0] low_cnt_reg;
   logic [16:0] last_low_reg;
   logic [16:0] high_cnt_reg;
   logic [16:0] m_cnt_reg;
   logic [16:0] s_cnt_reg;
   logic [16:0] wait_cnt_reg;
   logic        armed_reg;
   // Pulse length counters, saturating except the presence wait counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_reg  <= 17'h00000;
         last_low_reg <= 17'h00000;
         high_cnt_reg <= 17'h1FFFF;
         m_cnt_reg    <= 17'h00000;
         s_cnt_reg    <= 17'h00000;
         wait_cnt_reg <= 17'h00000;
         armed_reg    <= 1'b0;
      end else begin
         low_cnt_reg  <= line ? 17'h00000 : low_cnt_reg + {16'h0000, ~&low_cnt_reg};
         high_cnt_reg <= line ? high_cnt_reg + {16'h0000, ~&high_cnt_reg} : 17'h00000;
         m_cnt_reg    <= m_drive_low ? m_cnt_reg + {16'h0000, ~&m_cnt_reg} : 17'h00000;
         s_cnt_reg    <= s_drive_low ? s_cnt_reg + {16'h0000, ~&s_cnt_reg} : 17'h00000;
         wait_cnt_reg <= armed_reg ? wait_cnt_reg + 17'h00001 : 17'h00000;
         if (line && low_cnt_reg != 17'h00000) begin
            last_low_reg <= low_cnt_reg;
         end
         if (line && low_cnt_reg >= LONG_LOW) begin
            armed_reg <= 1'b1;
         end else if (s_drive_low || m_drive_low) begin
            armed_reg <= 1'b0;
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence slot_start;
      $rose(m_drive_low);
   endsequence
   sequence pres_start;
      $rose(s_drive_low) && !m_drive_low;
   endsequence
   sequence read_zero_start;
      $rose(s_drive_low) && m_drive_low;
   endsequence
   AST_SLAVE_INIT: assert property (pres_start |-> last_low_reg >= MIN_RESET)
      else $error("slave pulled a released line without a reset before");
   AST_PRES_WAIT: assert property (pres_start |-> high_cnt_reg >= PRES_MIN)
      else $error("presence began too soon after reset release");
   AST_PRES_DUE: assert property (armed_reg |-> wait_cnt_reg <= PRES_DUE)
      else $error("no presence after long reset");
   AST_SLAVE_LOW_MAX: assert property (s_cnt_reg <= S_LOW_MAX)
      else $error("slave held line low too long");
   AST_READ_HOLD: assert property (read_zero_start |=> s_drive_low [*8])
      else $error("read zero pull too short");
   AST_MASTER_LOW: assert property ($fell(m_drive_low) |-> m_cnt_reg <= FAST_LOW || m_cnt_reg >= MIN_RESET)
      else $error("master low pulse of illegal length");
   AST_RECOVERY: assert property (slot_start |-> high_cnt_reg >= REC_MIN)
      else $error("slot started without recovery time");
   AST_READ_START: assert property (read_zero_start |-> m_cnt_reg <= 17'h00002)
      else $error("read zero pull started late in the slot");
   COV_READ_ZERO: cover property (read_zero_start);
endmodule

// [testbench/single_wire_slave_speed_link_tb.sv]
// Self-checking bench joining master and slave over the link
`include "swl_regs.svh"
module single_wire_slave_speed_link_tb
   import swl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [63:0] ROM_VAL = 64'h5A3C_0F96_1E2D_4B87;  // Arbitrary value
   logic ref_clk, rst_n, cmd_valid, cmd_bit, cmd_fast, cmd_ready, resp_valid, resp_bit;
   logic rx_valid, rx_ready, selected, fast_speed_flag, r;
   logic [1:0] cmd_op;
   logic [7:0] rx_data, tx_data, got;
   logic [7:0] exp_q [8];
   logic [31:0] lfsr_state = 32'h0000_0750;
   int n_errors = 0, check_count = 0, cycles = 0;
   swl_if swl_if_inst ();
   swl_master swl_master_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(swl_if_inst), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_bit(cmd_bit), .cmd_fast(cmd_fast), .cmd_ready(cmd_ready),
      .resp_valid(resp_valid), .resp_bit(resp_bit));
   swl_slave #(.ROM_ID(ROM_VAL)) swl_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(swl_if_inst),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
      .selected(selected), .fast_speed_flag(fast_speed_flag));
   swl_link_props swl_link_props_inst (.ref_clk(ref_clk), .rst_n(rst_n), .m_drive_low(swl_if_inst.m_drive_low),
      .s_drive_low(swl_if_inst.s_drive_low), .line(swl_if_inst.line));
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [63:0] flip_bit(input logic [63:0] v, input logic [5:0] i);
      return v ^ (64'h0000_0000_0000_0001 << i);
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic op(input logic [1:0] o, input logic b, input logic f, output logic res);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= o;
      cmd_bit <= b;
      cmd_fast <= f;
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      @(negedge ref_clk);
      while (resp_valid !== 1'b1) @(negedge ref_clk);
      res = resp_bit;
   endtask
   task automatic bus_reset(input logic f);
      op(2'h0, 1'b0, f, r);
      check("presence", 64'h1, 64'(r));
   endtask
   task automatic send_byte(input logic [7:0] v, input logic f);
      for (int i = 0; i < 8; i++) op(2'h1, v[i], f, r);
   endtask
   task automatic send_rom(input logic [63:0] v, input logic f);
      for (int k = 0; k < 8; k++) send_byte(v[8*k +: 8], f);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 32'h001E_8480) begin
         n_errors++;
         $display("mismatch timeout expected done seen hang");
         stop_test();
      end
   end
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_bit = 1'b0;
      cmd_fast = 1'b0;
      rx_ready = 1'b1;
      tx_data = 8'hFF;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      bus_reset(1'b0);
      check("fast_speed_flag", 64'h0, 64'(fast_speed_flag));
      send_byte(`CMD_SKIP_FAST, 1'b0);
      check("fast_speed_flag", 64'h1, 64'(fast_speed_flag));
      check("selected", 64'h1, 64'(selected));
      @(posedge ref_clk);
      rx_ready <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         lfsr_state = lfsr_step(lfsr_state);
         exp_q[k] = (k == 0) ? 8'h00 : (k == 7) ? 8'hFF : lfsr_state[7:0];
         send_byte(exp_q[k], 1'b1);
      end
      check("rx_valid", 64'h1, 64'(rx_valid));
      for (int k = 0; k < 8; k++) begin
         lfsr_state = lfsr_step(lfsr_state);
         repeat (lfsr_state[1:0]) @(posedge ref_clk);
         @(posedge ref_clk);
         rx_ready <= 1'b1;
         @(negedge ref_clk);
         check("rx_data", 64'(exp_q[k]), 64'(rx_data));
         @(posedge ref_clk);
         rx_ready <= 1'b0;
      end
      @(negedge ref_clk);
      check("rx_valid", 64'h0, 64'(rx_valid));
      lfsr_state = lfsr_step(lfsr_state);
      @(posedge ref_clk);
      rx_ready <= 1'b1;
      tx_data <= lfsr_state[7:0];
      for (int i = 0; i < 8; i++) begin
         op(2'h2, 1'b1, 1'b1, r);
         got[i] = r;
      end
      check("read byte", 64'(lfsr_state[7:0]), 64'(got));
      @(posedge ref_clk);
      tx_data <= 8'hFF;
      rx_ready <= 1'b0;
      bus_reset(1'b1);
      check("fast_speed_flag", 64'h1, 64'(fast_speed_flag));
      lfsr_state = lfsr_step(lfsr_state);
      send_byte(lfsr_state[7:0] | 8'h80, 1'b1);
      check("selected", 64'h0, 64'(selected));
      check("fast_speed_flag", 64'h1, 64'(fast_speed_flag));
      bus_reset(1'b1);
      send_byte(`CMD_MATCH_FAST, 1'b1);
      send_rom(flip_bit(ROM_VAL, lfsr_state[13:8]), 1'b1);
      check("fast_speed_flag", 64'h1, 64'(fast_speed_flag));
      check("selected", 64'h0, 64'(selected));
      bus_reset(1'b0);
      check("fast_speed_flag", 64'h0, 64'(fast_speed_flag));
      send_byte(`CMD_MATCH_FAST, 1'b0);
      send_rom(ROM_VAL, 1'b1);
      check("fast_speed_flag", 64'h1, 64'(fast_speed_flag));
      check("selected", 64'h1, 64'(selected));
      lfsr_state = lfsr_step(lfsr_state);
      send_byte(lfsr_state[7:0], 1'b1);
      repeat (4) @(negedge ref_clk);
      check("rx_valid", 64'h1, 64'(rx_valid));
      check("rx_data", 64'(lfsr_state[7:0]), 64'(rx_data));
      stop_test();
   end
endmodule
